// ==== pifb_pkg.sv ====
// shared constants and types for the peripheral interrupt flag/enable bank
package pifb_pkg;

	// register bus shape
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 8;

	// register offsets
	localparam logic [ADDR_W-1:0] OFF_ENABLE_3  = 3'h0;
	localparam logic [ADDR_W-1:0] OFF_ENABLE_4  = 3'h1;
	localparam logic [ADDR_W-1:0] OFF_REQUEST_0 = 3'h2;
	localparam logic [ADDR_W-1:0] OFF_REQUEST_1 = 3'h3;
	localparam logic [ADDR_W-1:0] OFF_CONTROL   = 3'h4;

	// reset values
	localparam logic [DATA_W-1:0] RST_ENABLE  = 8'h00;
	localparam logic [DATA_W-1:0] RST_REQUEST = 8'h00;
	localparam logic [DATA_W-1:0] RST_CONTROL = 8'h00;

	// hardware-set, software-writable bits of each request register
	localparam logic [DATA_W-1:0] REQ0_HS_MASK = 8'h21;
	localparam logic [DATA_W-1:0] REQ1_HS_MASK = 8'hcf;

	// field positions, request register zero
	localparam int unsigned REQ0_TIMER0_OVF_BIT = 5;
	localparam int unsigned REQ0_PIN_CHANGE_BIT = 4;
	localparam int unsigned REQ0_EXT_PIN_BIT    = 0;

	// field positions, request register one
	localparam int unsigned REQ1_TIMER1_GATE_BIT = 7;
	localparam int unsigned REQ1_ADC_DONE_BIT    = 6;
	localparam int unsigned REQ1_UART_RX_BIT     = 5;
	localparam int unsigned REQ1_UART_TX_BIT     = 4;
	localparam int unsigned REQ1_SYNC_DONE_BIT   = 3;
	localparam int unsigned REQ1_SYNC_COLL_BIT   = 2;
	localparam int unsigned REQ1_TIMER2_BIT      = 1;
	localparam int unsigned REQ1_TIMER1_OVF_BIT  = 0;

	// field positions, control register
	localparam int unsigned CTRL_GLOBAL_EN_BIT = 7;
	localparam int unsigned CTRL_PERIPH_EN_BIT = 6;
	localparam logic [DATA_W-1:0] CTRL_MASK    = 8'hc0;

	// width of the per-pin change flag summary input
	localparam int unsigned PIN_FLAGS_W = 8;

	// one-cycle event pulses from the peripherals
	typedef struct packed {
		logic timer0_ovf;
		logic ext_pin;
		logic timer1_gate;
		logic adc_done;
		logic sync_serial_done;
		logic sync_serial_collision;
		logic timer2_match;
		logic timer1_ovf;
	} pifb_event_t;

endpackage

// ==== pifb_bank.sv ====
// peripheral interrupt flag and enable register bank
// Summary of operation
// RULE1: flags set by events regardless of enables
// RULE2: software clears stale flag before enabling
// RULE3: enable three: eight read/write source enables
// RULE4: enable four: eight read/write source enables
// RULE5: all enables reset to zero; enables zero and one are inputs here that reset does not clear
// RULE6: timer0 overflow sets sticky request bit five
// RULE7: pin change bit is OR of pin flags
// RULE8: external pin event sets sticky bit zero
// RULE9: unused request zero bits read zero
// RULE10: timer1 gate closing sets bit seven
// RULE11: conversion complete sets bit six
// RULE12: receive buffer not empty reads bit five
// RULE13: transmit buffer empty reads bit four
// RULE14: serial transfer complete sets bit three
// RULE15: bus collision sets sticky bit two
// RULE16: timer2 period match sets sticky bit one
// RULE17: timer1 overflow sets sticky bit zero
// RULE18: flags software writable, reset to zero
// RULE19: peripheral master enable gates core request
// RULE20: global enable gates every core request
// RULE21: request is OR of flag AND enable
`timescale 1ns/1ps
`default_nettype none

module pifb_bank (
	input  wire logic                          mclk_i,
	input  wire logic                          rstn_i,
	input  wire logic [pifb_pkg::ADDR_W-1:0]   addr_i,
	input  wire logic [pifb_pkg::DATA_W-1:0]   wdata_i,
	input  wire logic                          wr_i,
	input  wire logic                          rd_i,
	output logic      [pifb_pkg::DATA_W-1:0]   rdata_o,
	input  wire pifb_pkg::pifb_event_t         event_i,
	input  wire logic [pifb_pkg::PIN_FLAGS_W-1:0] per_pin_change_flags_i,
	input  wire logic                          uart_rx_nonempty_i,
	input  wire logic                          uart_tx_empty_i,
	input  wire logic [pifb_pkg::DATA_W-1:0]   periph_irq_enable_0_i,
	input  wire logic [pifb_pkg::DATA_W-1:0]   periph_irq_enable_1_i,
	input  wire logic [pifb_pkg::DATA_W-1:0]   periph_irq_request_3_i,
	input  wire logic [pifb_pkg::DATA_W-1:0]   periph_irq_request_4_i,
	output logic                               periph_req_o,
	output logic                               core_irq_o
);

	logic [pifb_pkg::DATA_W-1:0] periph_irq_enable_3;
	logic [pifb_pkg::DATA_W-1:0] periph_irq_enable_4;
	logic [pifb_pkg::DATA_W-1:0] req0_hs;
	logic [pifb_pkg::DATA_W-1:0] req1_hs;
	logic [pifb_pkg::DATA_W-1:0] irq_control_reg;
	logic [pifb_pkg::DATA_W-1:0] set0;
	logic [pifb_pkg::DATA_W-1:0] set1;
	logic [pifb_pkg::DATA_W-1:0] next_req0;
	logic [pifb_pkg::DATA_W-1:0] next_req1;
	logic [pifb_pkg::DATA_W-1:0] periph_irq_request_0;
	logic [pifb_pkg::DATA_W-1:0] periph_irq_request_1;
	logic [pifb_pkg::DATA_W-1:0] next_rdata;
	logic                        wr_en3;
	logic                        wr_en4;
	logic                        wr_req0;
	logic                        wr_req1;
	logic                        wr_ctrl;
	logic                        global_irq_en;
	logic                        peripheral_irq_master_en;
	logic                        next_periph_req;

	// address decode
	assign wr_en3  = wr_i && (addr_i == pifb_pkg::OFF_ENABLE_3);
	assign wr_en4  = wr_i && (addr_i == pifb_pkg::OFF_ENABLE_4);
	assign wr_req0 = wr_i && (addr_i == pifb_pkg::OFF_REQUEST_0);
	assign wr_req1 = wr_i && (addr_i == pifb_pkg::OFF_REQUEST_1);
	assign wr_ctrl = wr_i && (addr_i == pifb_pkg::OFF_CONTROL);

	assign global_irq_en            = irq_control_reg[pifb_pkg::CTRL_GLOBAL_EN_BIT];
	assign peripheral_irq_master_en = irq_control_reg[pifb_pkg::CTRL_PERIPH_EN_BIT];

	// enable register three
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			periph_irq_enable_3 <= pifb_pkg::RST_ENABLE; // [RULE5]
		end else if (wr_en3) begin
			periph_irq_enable_3 <= wdata_i; // [RULE3]
		end
	end

	// enable register four
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			periph_irq_enable_4 <= pifb_pkg::RST_ENABLE; // [RULE5]
		end else if (wr_en4) begin
			periph_irq_enable_4 <= wdata_i; // [RULE4]
		end
	end

	// control register: global and peripheral master enables
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_control_reg <= pifb_pkg::RST_CONTROL;
		end else if (wr_ctrl) begin
			irq_control_reg <= wdata_i & pifb_pkg::CTRL_MASK;
		end
	end

	// hardware set terms, independent of any enable
	always_comb begin
		set0 = '0;
		set0[pifb_pkg::REQ0_TIMER0_OVF_BIT]  = event_i.timer0_ovf; // [RULE6] [RULE1]
		set0[pifb_pkg::REQ0_EXT_PIN_BIT]     = event_i.ext_pin; // [RULE8] [RULE1]
		set1 = '0;
		set1[pifb_pkg::REQ1_TIMER1_GATE_BIT] = event_i.timer1_gate; // [RULE10]
		set1[pifb_pkg::REQ1_ADC_DONE_BIT]    = event_i.adc_done; // [RULE11]
		set1[pifb_pkg::REQ1_SYNC_DONE_BIT]   = event_i.sync_serial_done; // [RULE14]
		set1[pifb_pkg::REQ1_SYNC_COLL_BIT]   = event_i.sync_serial_collision; // [RULE15]
		set1[pifb_pkg::REQ1_TIMER2_BIT]      = event_i.timer2_match; // [RULE16]
		set1[pifb_pkg::REQ1_TIMER1_OVF_BIT]  = event_i.timer1_ovf; // [RULE17]
	end

	// software write replaces, a same-cycle event still wins
	always_comb begin
		next_req0 = wr_req0 ? (wdata_i & pifb_pkg::REQ0_HS_MASK) : req0_hs; // [RULE18] [RULE9]
		next_req0 = next_req0 | set0; // [RULE1]
		next_req1 = wr_req1 ? (wdata_i & pifb_pkg::REQ1_HS_MASK) : req1_hs; // [RULE18]
		next_req1 = next_req1 | set1; // [RULE1]
	end

	// sticky flags of request register zero
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			req0_hs <= pifb_pkg::RST_REQUEST; // [RULE18]
		end else begin
			req0_hs <= next_req0; // [RULE6] [RULE8]
		end
	end

	// sticky flags of request register one
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			req1_hs <= pifb_pkg::RST_REQUEST; // [RULE18]
		end else begin
			req1_hs <= next_req1; // [RULE14] [RULE15] [RULE16] [RULE17]
		end
	end

	// visible request registers with live read-only bits
	always_comb begin
		periph_irq_request_0 = req0_hs;
		periph_irq_request_0[pifb_pkg::REQ0_PIN_CHANGE_BIT] = |per_pin_change_flags_i; // [RULE7]
		periph_irq_request_1 = req1_hs;
		periph_irq_request_1[pifb_pkg::REQ1_UART_RX_BIT] = uart_rx_nonempty_i; // [RULE12]
		periph_irq_request_1[pifb_pkg::REQ1_UART_TX_BIT] = uart_tx_empty_i; // [RULE13]
	end

	// read mux, unmapped reads return zero
	always_comb begin
		next_rdata = '0;
		if (rd_i) begin
			unique case (addr_i)
				pifb_pkg::OFF_ENABLE_3:  next_rdata = periph_irq_enable_3;
				pifb_pkg::OFF_ENABLE_4:  next_rdata = periph_irq_enable_4;
				pifb_pkg::OFF_REQUEST_0: next_rdata = periph_irq_request_0; // [RULE9]
				pifb_pkg::OFF_REQUEST_1: next_rdata = periph_irq_request_1;
				pifb_pkg::OFF_CONTROL:   next_rdata = irq_control_reg;
				default:                 next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= next_rdata;
		end
	end

	// combined peripheral request
	assign next_periph_req =
		|(periph_irq_request_0 & periph_irq_enable_0_i) |
		|(periph_irq_request_1 & periph_irq_enable_1_i) |
		|(periph_irq_request_3_i & periph_irq_enable_3) |
		|(periph_irq_request_4_i & periph_irq_enable_4); // [RULE21]

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			periph_req_o <= 1'b0;
		end else begin
			periph_req_o <= next_periph_req; // [RULE21]
		end
	end

	// request to the core, gated by both enables
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			core_irq_o <= 1'b0;
		end else begin
			core_irq_o <= next_periph_req && peripheral_irq_master_en
				&& global_irq_en; // [RULE19] [RULE20]
		end
	end

	// checks
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rstn_i);

	a_timer0_flag_set: assert property ( // [RULE6]
		event_i.timer0_ovf |=> req0_hs[pifb_pkg::REQ0_TIMER0_OVF_BIT])
		else $error("timer0 flag not set by event");

	a_timer0_flag_hold: assert property ( // [RULE6]
		req0_hs[pifb_pkg::REQ0_TIMER0_OVF_BIT] && !wr_req0
		|=> req0_hs[pifb_pkg::REQ0_TIMER0_OVF_BIT])
		else $error("timer0 flag dropped without a write");

	a_ext_flag_set: assert property ( // [RULE8]
		event_i.ext_pin ##0 wr_req0 |=> req0_hs[pifb_pkg::REQ0_EXT_PIN_BIT])
		else $error("external flag lost to a clear");

	a_pin_change_read: assert property ( // [RULE7]
		rd_i && addr_i == pifb_pkg::OFF_REQUEST_0
		|=> rdata_o[pifb_pkg::REQ0_PIN_CHANGE_BIT] == $past(|per_pin_change_flags_i))
		else $error("pin change summary wrong");

	a_req0_unused_zero: assert property ( // [RULE9]
		rd_i && addr_i == pifb_pkg::OFF_REQUEST_0 |=> (rdata_o & 8'hce) == 8'h00)
		else $error("unused request bits not zero");

	a_uart_bits_live: assert property ( // [RULE12] [RULE13]
		rd_i && addr_i == pifb_pkg::OFF_REQUEST_1
		|=> rdata_o[pifb_pkg::REQ1_UART_RX_BIT] == $past(uart_rx_nonempty_i)
		&& rdata_o[pifb_pkg::REQ1_UART_TX_BIT] == $past(uart_tx_empty_i))
		else $error("uart status bits wrong");

	a_req1_flags_set: assert property ( // [RULE10] [RULE11] [RULE14] [RULE15]
		|set1 |=> (req1_hs & $past(set1)) == $past(set1))
		else $error("request one flag not set");

	a_enable3_write: assert property ( // [RULE3]
		wr_en3 ##1 rd_i && addr_i == pifb_pkg::OFF_ENABLE_3 && !wr_en3
		|=> rdata_o == $past(wdata_i, 2))
		else $error("enable three readback wrong");

	a_enable4_write: assert property ( // [RULE4]
		wr_en4 |=> periph_irq_enable_4 == $past(wdata_i))
		else $error("enable four not stored");

	a_global_gate: assert property ( // [RULE20]
		!global_irq_en |=> !core_irq_o)
		else $error("core request with global enable low");

	a_periph_gate: assert property ( // [RULE19]
		!peripheral_irq_master_en |=> !core_irq_o)
		else $error("core request with peripheral enable low");

	a_request_or: assert property ( // [RULE21]
		next_periph_req |=> periph_req_o)
		else $error("peripheral request not raised");

	a_ext_flag_hold: assert property ( // [RULE8]
		req0_hs[pifb_pkg::REQ0_EXT_PIN_BIT] && !wr_req0
		|=> req0_hs[pifb_pkg::REQ0_EXT_PIN_BIT])
		else $error("external flag dropped without a write");

	a_ext_set_any: assert property ( // [RULE8]
		event_i.ext_pin
		|=> req0_hs[pifb_pkg::REQ0_EXT_PIN_BIT])
		else $error("external flag not set by event");

	a_timer0_clear: assert property ( // [RULE6]
		wr_req0 && !event_i.timer0_ovf
		|=> req0_hs[pifb_pkg::REQ0_TIMER0_OVF_BIT] == $past(wdata_i[pifb_pkg::REQ0_TIMER0_OVF_BIT]))
		else $error("timer0 flag write not taken");

	a_req0_unused_regs: assert property ( // [RULE9]
		(req0_hs & 8'hde)
		== 8'h00)
		else $error("unused request zero bits stored");

	a_req0_write: assert property ( // [RULE18]
		wr_req0 && set0 == 8'h00
		|=> req0_hs == ($past(wdata_i) & 8'h21))
		else $error("request zero write not stored");

	a_req1_write: assert property ( // [RULE18]
		wr_req1 && set1 == 8'h00
		|=> req1_hs == ($past(wdata_i) & 8'hcf))
		else $error("request one write not stored");

	a_req1_hold: assert property ( // [RULE18]
		!wr_req1
		|=> (req1_hs & $past(req1_hs)) == $past(req1_hs))
		else $error("request one flag dropped without a write");

	a_gate_set: assert property ( // [RULE10]
		event_i.timer1_gate
		|=> req1_hs[pifb_pkg::REQ1_TIMER1_GATE_BIT])
		else $error("gate flag not set");

	a_adc_set: assert property ( // [RULE11]
		event_i.adc_done
		|=> req1_hs[pifb_pkg::REQ1_ADC_DONE_BIT])
		else $error("conversion flag not set");

	a_serial_done_set: assert property ( // [RULE14]
		event_i.sync_serial_done
		|=> req1_hs[pifb_pkg::REQ1_SYNC_DONE_BIT])
		else $error("serial done flag not set");

	a_collision_set: assert property ( // [RULE15]
		event_i.sync_serial_collision
		|=> req1_hs[pifb_pkg::REQ1_SYNC_COLL_BIT])
		else $error("collision flag not set");

	a_timer2_set: assert property ( // [RULE16]
		event_i.timer2_match
		|=> req1_hs[pifb_pkg::REQ1_TIMER2_BIT])
		else $error("timer2 flag not set");

	a_timer1_ovf_set: assert property ( // [RULE17]
		event_i.timer1_ovf
		|=> req1_hs[pifb_pkg::REQ1_TIMER1_OVF_BIT])
		else $error("timer1 overflow flag not set");

	a_enable3_store: assert property ( // [RULE3]
		wr_en3
		|=> periph_irq_enable_3 == $past(wdata_i))
		else $error("enable three not stored");

	a_enable3_hold: assert property ( // [RULE3]
		!wr_en3
		|=> $stable(periph_irq_enable_3))
		else $error("enable three changed without a write");

	a_enable4_hold: assert property ( // [RULE4]
		!wr_en4
		|=> $stable(periph_irq_enable_4))
		else $error("enable four changed without a write");

	a_enable4_read: assert property ( // [RULE4]
		rd_i && addr_i == pifb_pkg::OFF_ENABLE_4
		|=> rdata_o == $past(periph_irq_enable_4))
		else $error("enable four readback wrong");

	a_ctrl_write: assert property ( // [RULE20]
		wr_ctrl
		|=> irq_control_reg == ($past(wdata_i) & 8'hc0))
		else $error("control write not stored");

	a_ctrl_unused_zero: assert property ( // [RULE20]
		(irq_control_reg & 8'h3f)
		== 8'h00)
		else $error("unused control bits stored");

	a_core_raise: assert property ( // [RULE20]
		next_periph_req && global_irq_en && peripheral_irq_master_en
		|=> core_irq_o)
		else $error("core request not raised");

	a_core_needs_req: assert property ( // [RULE21]
		!next_periph_req
		|=> !core_irq_o)
		else $error("core request without a source");

	a_request_drop: assert property ( // [RULE21]
		!next_periph_req
		|=> !periph_req_o)
		else $error("peripheral request without a source");

	c_core_request: cover property (
		core_irq_o);

	c_pin_summary_read: cover property (
		rd_i && addr_i == pifb_pkg::OFF_REQUEST_0 ##1 rdata_o[pifb_pkg::REQ0_PIN_CHANGE_BIT]);

	c_timer0_to_core: cover property (
		event_i.timer0_ovf ##[1:4] core_irq_o);

	c_clear_with_event: cover property (
		wr_req0 && event_i.ext_pin);

	c_req1_read: cover property (
		rd_i && addr_i == pifb_pkg::OFF_REQUEST_1 ##1 rdata_o != 8'h00);

endmodule // pifb_bank

`default_nettype wire

// ==== pifb_src.sv ====
// event source model driving peripheral event pulses that follow fire_i one cycle late
`timescale 1ns/1ps
`default_nettype none

module pifb_src (
	input  wire logic                  mclk_i,
	input  wire logic                  rstn_i,
	input  wire logic [7:0]            fire_i,
	output var  pifb_pkg::pifb_event_t event_o
);
	// each pulse is fire_i delayed one cycle, high for as many cycles as fire_i is held
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			event_o <= '0;
		end else begin
			event_o <= pifb_pkg::pifb_event_t'(fire_i);
		end
	end
endmodule // pifb_src

`default_nettype wire

// ==== pifb_bank_test.sv ====
// self-checking testbench for the peripheral interrupt flag bank
`timescale 1ns/1ps
`default_nettype none

module pifb_bank_test;
	logic                  mclk_i;
	logic                  rstn_i;
	logic [2:0]            addr;
	logic [7:0]            wdata;
	logic                  wr;
	logic                  rd;
	logic [7:0]            rdata;
	logic [7:0]            fire;
	pifb_pkg::pifb_event_t ev;
	logic [7:0]            pins;
	logic                  rx;
	logic                  tx;
	logic [7:0]            en0;
	logic [7:0]            en1;
	logic [7:0]            rq3;
	logic [7:0]            rq4;
	logic                  preq;
	logic                  cirq;
	int                    miscompares;
	int                    total_checks;
	int                    pos_tab [8] = '{0, 1, 2, 3, 6, 7, 0, 5};

	pifb_src src_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .fire_i(fire), .event_o(ev));

	pifb_bank dut_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .event_i(ev), .per_pin_change_flags_i(pins),
		.uart_rx_nonempty_i(rx), .uart_tx_empty_i(tx), .periph_irq_enable_0_i(en0),
		.periph_irq_enable_1_i(en1), .periph_irq_request_3_i(rq3),
		.periph_irq_request_4_i(rq4), .periph_req_o(preq), .core_irq_o(cirq));

	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
			miscompares++;
		end
	endtask

	task automatic do_reset();
		rstn_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		rstn_i <= 1'b1;
	endtask

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk_i);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		@(posedge mclk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_i);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	task automatic fire_ev(input logic [7:0] m);
		@(posedge mclk_i);
		fire <= m;
		@(posedge mclk_i);
		fire <= 8'h00;
		repeat (2) @(posedge mclk_i);
	endtask

	task automatic irq_chk(input logic p, input logic c);
		repeat (3) @(posedge mclk_i);
		#1;
		chk({6'h00, preq, cirq}, {6'h00, p, c});
	endtask

	initial begin
		logic [2:0] ra;
		rstn_i = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		fire = 8'h00;
		{pins, rx, tx, en0, en1, rq3, rq4} = '0;
		miscompares = 0;
		total_checks = 0;
		do_reset();
		for (int i = 0; i < 6; i++) rd_chk(i[2:0], 8'h00);
		foreach (pos_tab[i]) if (i < 2) begin
			wr_reg(pifb_pkg::OFF_ENABLE_3, i[0] ? 8'h5a : 8'ha5);
			wr_reg(pifb_pkg::OFF_ENABLE_4, i[0] ? 8'ha5 : 8'h5a);
			rd_chk(pifb_pkg::OFF_ENABLE_3, i[0] ? 8'h5a : 8'ha5);
			rd_chk(pifb_pkg::OFF_ENABLE_4, i[0] ? 8'ha5 : 8'h5a);
		end
		wr_reg(pifb_pkg::OFF_REQUEST_0, 8'hff);
		rd_chk(pifb_pkg::OFF_REQUEST_0, 8'h21);
		wr_reg(pifb_pkg::OFF_REQUEST_1, 8'hff);
		rd_chk(pifb_pkg::OFF_REQUEST_1, 8'hcf);
		wr_reg(pifb_pkg::OFF_REQUEST_0, 8'h00);
		wr_reg(pifb_pkg::OFF_REQUEST_1, 8'h00);
		pins <= 8'h80;
		wr_reg(pifb_pkg::OFF_REQUEST_0, 8'h00);
		rd_chk(pifb_pkg::OFF_REQUEST_0, 8'h10);
		pins <= 8'h00;
		rd_chk(pifb_pkg::OFF_REQUEST_0, 8'h00);
		rx <= 1'b1;
		rd_chk(pifb_pkg::OFF_REQUEST_1, 8'h20);
		rx <= 1'b0;
		tx <= 1'b1;
		rd_chk(pifb_pkg::OFF_REQUEST_1, 8'h10);
		tx <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			ra = (i >= 6) ? pifb_pkg::OFF_REQUEST_0 : pifb_pkg::OFF_REQUEST_1;
			fire_ev(8'h01 << i);
			rd_chk(ra, 8'h01 << pos_tab[i]);
			rd_chk(ra, 8'h01 << pos_tab[i]);
			wr_reg(ra, 8'h00);
			rd_chk(ra, 8'h00);
		end
		fork
			fire_ev(8'h40);
			begin
				@(posedge mclk_i);
				wr_reg(pifb_pkg::OFF_REQUEST_0, 8'h00);
			end
		join
		rd_chk(pifb_pkg::OFF_REQUEST_0, 8'h01);
		wr_reg(pifb_pkg::OFF_REQUEST_0, 8'h00);
		fire_ev(8'h01);
		irq_chk(1'b0, 1'b0);
		en1 <= 8'h01;
		irq_chk(1'b1, 1'b0);
		wr_reg(pifb_pkg::OFF_CONTROL, 8'h80);
		irq_chk(1'b1, 1'b0);
		wr_reg(pifb_pkg::OFF_CONTROL, 8'h40);
		irq_chk(1'b1, 1'b0);
		wr_reg(pifb_pkg::OFF_CONTROL, 8'hff);
		rd_chk(pifb_pkg::OFF_CONTROL, 8'hc0);
		irq_chk(1'b1, 1'b1);
		wr_reg(pifb_pkg::OFF_REQUEST_1, 8'h00);
		irq_chk(1'b0, 1'b0);
		wr_reg(pifb_pkg::OFF_ENABLE_3, 8'h80);
		rq3 <= 8'h80;
		irq_chk(1'b1, 1'b1);
		wr_reg(pifb_pkg::OFF_ENABLE_3, 8'h7f);
		irq_chk(1'b0, 1'b0);
		rq4 <= 8'h01;
		wr_reg(pifb_pkg::OFF_ENABLE_4, 8'h01);
		irq_chk(1'b1, 1'b1);
		rq4 <= 8'h00;
		pins <= 8'h01;
		en0 <= 8'h10;
		irq_chk(1'b1, 1'b1);
		do_reset();
		irq_chk(1'b1, 1'b0);
		rd_chk(pifb_pkg::OFF_ENABLE_3, 8'h00);
		rd_chk(pifb_pkg::OFF_REQUEST_0, 8'h10);
		rd_chk(pifb_pkg::OFF_CONTROL, 8'h00);
		stop_test();
	end

	// cut a hang short
	initial begin
		#200000;
		miscompares++;
		stop_test();
	end
endmodule // pifb_bank_test

`default_nettype wire
